// ===== rtl/pacoc_top.sv
// Output control of a pipelined 10-bit converter with an AHB-Lite register slave
//
// The register addresses and the AHB-Lite register port were decided locally.
`default_nettype none
// How it works
// - Each result leaves as a 10-bit parallel code, sample_code_msb as bit 9 and sample_code_lsb as bit 0.
// - A high output drive enable pin releases the data outputs, a low one lets them drive.
// - The drive enable pin is pulled down, so an open pin means normal driving.
// - A high sleep request powers the converter down, a low one lets it convert.
// - Span select high picks the 2V range and low picks the 1V range.
// - Reference source select high picks the external reference and low the internal one.
// - New sample codes become valid on a rising clock edge.
// - A sample taken on one edge reaches the outputs five clock cycles later.
// - Nine stage results are merged by error correction into a 10-bit code without missing codes.
// - The input is sampled on every rising clock edge except while the converter is powered down.
// - Codes are straight offset binary, so inverting the top bit gives two's complement.
// - Span and reference pins are pulled up, so open pins give the 2V range with an external reference.
module pacoc_top #(
    parameter int LATENCY = pacoc_pkg::LATENCY
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [pacoc_pkg::RAW_W-1:0] stage_codes_in,
    input wire logic output_drive_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic span_select_in,
    input wire logic reference_source_select_in,
    output logic [pacoc_pkg::CODE_W-1:0] sample_code_out,
    output logic sample_code_oe_out,
    output logic code_valid_out,
    output logic power_down_out,
    output logic span_2v_out,
    output logic ext_ref_out,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);
    localparam int DLY = LATENCY - 2;

    // Pin synchroniser and settled configuration
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] cfg;
    logic [3:0] next_cfg;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_s1 <= pacoc_pkg::PIN_PULL_DEFAULT;
            pin_s2 <= pacoc_pkg::PIN_PULL_DEFAULT;
            pin_s3 <= pacoc_pkg::PIN_PULL_DEFAULT;
        end else begin
            pin_s1 <= {reference_source_select_in, span_select_in, sleep_request_in, output_drive_enable_n_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // A pin change counts only once two later stages agree
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_cfg[i] = (pin_s2[i] == pin_s3[i]) ? pin_s3[i] : cfg[i];
        end
    end

    // reset state equals the pull-down default
    // reset state equals the pull-up defaults
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cfg <= pacoc_pkg::PIN_PULL_DEFAULT;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Software control bits
    logic [1:0] ctrl;
    logic [1:0] next_ctrl;
    logic sleep_eff;
    logic drive_eff;

    // pin or software may request power down
    assign sleep_eff = cfg[pacoc_pkg::PIN_SLEEP] | ctrl[pacoc_pkg::CTRL_SLEEP_BIT];
    assign drive_eff = ~cfg[pacoc_pkg::PIN_OE_N] & ~ctrl[pacoc_pkg::CTRL_HIZ_BIT];

    // Power state
    pacoc_pkg::pacoc_pwr_e state;
    pacoc_pkg::pacoc_pwr_e next_state;
    logic [2:0] fill;
    logic [2:0] next_fill;

    always_comb begin
        next_state = state;
        next_fill = fill;
        case (state)
            pacoc_pkg::PACOC_RUN: begin
                if (sleep_eff) begin
                    next_state = pacoc_pkg::PACOC_SLEEP;
                end
            end
            pacoc_pkg::PACOC_SLEEP: begin
                next_fill = '0;
                if (!sleep_eff) begin
                    next_state = pacoc_pkg::PACOC_WAKE;
                end
            end
            pacoc_pkg::PACOC_WAKE: begin
                next_fill = fill + 3'h1;
                if (sleep_eff) begin
                    next_state = pacoc_pkg::PACOC_SLEEP;
                end else if (fill == 3'(LATENCY - 1)) begin
                    next_state = pacoc_pkg::PACOC_RUN;
                end
            end
            default: begin
                next_state = pacoc_pkg::PACOC_SLEEP;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state <= pacoc_pkg::PACOC_WAKE;
            fill <= '0;
        end else begin
            state <= next_state;
            fill <= next_fill;
        end
    end

    // Sample path
    logic converting;
    logic [pacoc_pkg::RAW_W-1:0] raw;
    logic [pacoc_pkg::RAW_W-1:0] next_raw;
    logic [pacoc_pkg::CODE_W-1:0] dly [DLY];
    logic [pacoc_pkg::CODE_W-1:0] next_dly [DLY];
    logic [pacoc_pkg::CODE_W-1:0] next_sample_code;
    pacoc_stage_if stage_link ();

    assign converting = (state != pacoc_pkg::PACOC_SLEEP) && !sleep_eff;
    assign stage_link.stage_codes = raw;

    pacoc_corrector #(
        .STAGES(pacoc_pkg::STAGE_COUNT)
    ) u_corrector (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .stage_link(stage_link)
    );

    // Frozen while asleep so the last code stays on the pins
    always_comb begin
        next_raw = converting ? stage_codes_in : raw;
        // corrector plus delay line plus output stage make five edges
        next_dly[0] = converting ? stage_link.code : dly[0];
        for (int i = 1; i < DLY; i++) begin
            next_dly[i] = converting ? dly[i-1] : dly[i];
        end
        // code passes as offset binary, unaltered
        next_sample_code = converting ? dly[DLY-1] : sample_code_out;
    end

    // outputs change only at the rising edge
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            raw <= '0;
            for (int i = 0; i < DLY; i++) begin
                dly[i] <= '0;
            end
            sample_code_out <= '0;
        end else begin
            raw <= next_raw;
            dly <= next_dly;
            // bit 9 is sample_code_msb, bit 0 sample_code_lsb
            sample_code_out <= next_sample_code;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            sample_code_oe_out <= 1'b0;
            code_valid_out <= 1'b0;
            power_down_out <= 1'b0;
            span_2v_out <= 1'b1;
            ext_ref_out <= 1'b1;
        end else begin
            sample_code_oe_out <= drive_eff;
            code_valid_out <= (next_state == pacoc_pkg::PACOC_RUN);
            power_down_out <= sleep_eff;
            span_2v_out <= cfg[pacoc_pkg::PIN_SPAN];
            ext_ref_out <= cfg[pacoc_pkg::PIN_REF];
        end
    end

    // AHB-Lite slave, zero wait states, read data registered in the address phase
    logic wr_pend;
    logic next_wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic take;

    assign take = hsel_in && htrans_in[1] && hready_in;

    always_comb begin
        next_wr_pend = take && hwrite_in;
        next_wr_addr = take ? haddr_in[7:0] : wr_addr;
        next_hrdata = '0;
        next_ctrl = ctrl;
        if (take && !hwrite_in) begin
            if (haddr_in[7:0] == pacoc_pkg::CTRL_OFS) begin
                next_hrdata = {30'h0, ctrl};
            end else if (haddr_in[7:0] == pacoc_pkg::STATUS_OFS) begin
                next_hrdata[pacoc_pkg::STAT_SLEEP_BIT] = power_down_out;
                next_hrdata[pacoc_pkg::STAT_DRIVE_BIT] = sample_code_oe_out;
                next_hrdata[pacoc_pkg::STAT_SPAN_BIT] = span_2v_out;
                next_hrdata[pacoc_pkg::STAT_EXTREF_BIT] = ext_ref_out;
                next_hrdata[pacoc_pkg::STAT_VALID_BIT] = code_valid_out;
            end else if (haddr_in[7:0] == pacoc_pkg::CODE_OFS) begin
                next_hrdata = {22'h0, sample_code_out};
            end
        end
        if (wr_pend && wr_addr == pacoc_pkg::CTRL_OFS) begin
            next_ctrl = hwdata_in[1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata_out <= '0;
            ctrl <= pacoc_pkg::CTRL_RESET;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata_out <= next_hrdata;
            ctrl <= next_ctrl;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end
endmodule : pacoc_top
`default_nettype wire

// ===== rtl/pacoc_pkg.sv
// Shared constants and types for the pipelined converter output control block
`default_nettype none
package pacoc_pkg;
    localparam int CODE_W = 10;
    localparam int STAGE_COUNT = 9;
    localparam int STAGE_BITS = 2;
    localparam int RAW_W = STAGE_COUNT * STAGE_BITS;
    localparam int LATENCY = 5;
    localparam logic [1:0] STAGE_MAX_CODE = 2'h2;
    localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CODE_OFS = 8'h08;
    // Control fields
    localparam int CTRL_SLEEP_BIT = 0;
    localparam int CTRL_HIZ_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Status fields
    localparam int STAT_SLEEP_BIT = 0;
    localparam int STAT_DRIVE_BIT = 1;
    localparam int STAT_SPAN_BIT = 2;
    localparam int STAT_EXTREF_BIT = 3;
    localparam int STAT_VALID_BIT = 4;
    // Pin vector order {reference_source_select, span_select, sleep_request, output drive enable (low)}
    localparam int PIN_OE_N = 0;
    localparam int PIN_SLEEP = 1;
    localparam int PIN_SPAN = 2;
    localparam int PIN_REF = 3;
    // Pull defaults: drive enable pulled down, span and reference pulled up
    localparam logic [3:0] PIN_PULL_DEFAULT = 4'hC;
    localparam logic [2:0] FILL_W_MAX = 3'h5;
    typedef enum logic [1:0] {
        PACOC_RUN = 2'h0,
        PACOC_SLEEP = 2'h1,
        PACOC_WAKE = 2'h3
    } pacoc_pwr_e;
endpackage : pacoc_pkg
`default_nettype wire

// ===== rtl/pacoc_stage_if.sv
// Stage partial results and corrected code between capture and correction logic
`default_nettype none
interface pacoc_stage_if;
    logic [pacoc_pkg::RAW_W-1:0] stage_codes;
    logic [pacoc_pkg::CODE_W-1:0] code;
    modport feed (output stage_codes, input code);
    modport corr (input stage_codes, output code);
endinterface : pacoc_stage_if
`default_nettype wire

// ===== rtl/pacoc_corrector.sv
// Digital error correction merging overlapping stage results into one code
`default_nettype none
module pacoc_corrector #(
    parameter int STAGES = pacoc_pkg::STAGE_COUNT
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    pacoc_stage_if.corr stage_link
);
    logic [pacoc_pkg::CODE_W-1:0] code;
    logic [pacoc_pkg::CODE_W-1:0] next_code;

    always_comb begin
        logic [pacoc_pkg::CODE_W:0] sum;
        logic [1:0] digit;
        sum = '0;
        digit = '0;
        for (int i = 0; i < STAGES; i++) begin
            digit = stage_link.stage_codes[(STAGES-1-i)*pacoc_pkg::STAGE_BITS +: pacoc_pkg::STAGE_BITS];
            // Redundant stages never legally emit the top code; clamp it so a glitch cannot skip codes
            if (i < STAGES - 1 && digit > pacoc_pkg::STAGE_MAX_CODE) begin
                digit = pacoc_pkg::STAGE_MAX_CODE;
            end
            sum = sum + ((pacoc_pkg::CODE_W+1)'(digit) << (STAGES - 1 - i));
        end
        if (sum > {1'b0, pacoc_pkg::CODE_MAX}) begin
            next_code = pacoc_pkg::CODE_MAX;
        end else begin
            next_code = sum[pacoc_pkg::CODE_W-1:0];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            code <= '0;
        end else begin
            code <= next_code;
        end
    end

    assign stage_link.code = code;
endmodule : pacoc_corrector
`default_nettype wire

// ===== dv/pacoc_top_chk.sv
// Port-level assertions for the converter output control block
`default_nettype none
module pacoc_top_chk #(
    parameter int LATENCY = pacoc_pkg::LATENCY
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic output_drive_enable_n_in,
    input wire logic sleep_request_in,
    input wire logic span_select_in,
    input wire logic reference_source_select_in,
    input wire logic [pacoc_pkg::CODE_W-1:0] sample_code_out,
    input wire logic sample_code_oe_out,
    input wire logic code_valid_out,
    input wire logic power_down_out,
    input wire logic span_2v_out,
    input wire logic ext_ref_out,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // Pin to registered output spans five edges, so six settled samples are demanded
    AST_DRIVE_OFF: assert property (output_drive_enable_n_in [*6] |-> !sample_code_oe_out)
        else $error("data pins still driven");
    AST_SLEEP_ON: assert property (sleep_request_in [*6] |-> power_down_out)
        else $error("power down not entered");
    AST_FROZEN: assert property (power_down_out [*3] |-> $stable(sample_code_out))
        else $error("code moved while powered down");
    AST_NO_VALID_ASLEEP: assert property (power_down_out [*2] |-> !code_valid_out)
        else $error("valid while powered down");
    AST_SPAN: assert property ($stable(span_select_in) [*5] |-> span_2v_out == span_select_in)
        else $error("span output wrong");
    AST_REF: assert property ($stable(reference_source_select_in) [*5] |->
        ext_ref_out == reference_source_select_in) else $error("reference output wrong");
    AST_WAKE: assert property ($fell(power_down_out) |-> !code_valid_out [*3] ##[1:5] code_valid_out)
        else $error("valid timing after wake wrong");
    AST_RDATA_IDLE: assert property (!(hsel_in && htrans_in[1] && hready_in) |=> hrdata_out == 32'h0)
        else $error("read data outside a read");
    AST_OKAY: assert property (hreadyout_out && !hresp_out)
        else $error("bus not ready or not okay");
    cover property ($rose(code_valid_out));
    cover property ($fell(sample_code_oe_out));
    cover property ($fell(power_down_out));
endmodule : pacoc_top_chk
bind pacoc_top pacoc_top_chk #(.LATENCY(LATENCY)) u_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .output_drive_enable_n_in(output_drive_enable_n_in), .sleep_request_in(sleep_request_in),
    .span_select_in(span_select_in), .reference_source_select_in(reference_source_select_in),
    .sample_code_out(sample_code_out), .sample_code_oe_out(sample_code_oe_out), .code_valid_out(code_valid_out),
    .power_down_out(power_down_out), .span_2v_out(span_2v_out), .ext_ref_out(ext_ref_out), .hsel_in(hsel_in),
    .htrans_in(htrans_in), .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out));
`default_nettype wire

// ===== dv/pacoc_capture_model.sv
// Downstream capture logic latching the parallel sample codes
`default_nettype none
module pacoc_capture_model #(
    parameter int LATENCY = 5
) (
    input wire logic mclk_in,
    input wire logic [9:0] code_in,
    input wire logic oe_in,
    input wire logic valid_in,
    output logic [9:0] pin_code_out,
    output logic [9:0] held_code_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] last = 10'h155;
    int skip = 0;
    // Released data pins have no pull, so they show the inverse of the last value
    always_comb pin_code_out = oe_in ? code_in : ~last;
    always_ff @(posedge mclk_in) begin
        if (oe_in) last <= code_in;
        // drop the first codes after a restart
        if (!valid_in) skip <= LATENCY;
        else if (skip > 0) skip <= skip - 1;
        else held_code_out <= pin_code_out;
    end
endmodule : pacoc_capture_model
`default_nettype wire

// ===== dv/pacoc_top_test.sv
// Self-checking testbench for the converter output control block
`default_nettype none
module pacoc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in, rst_in, oe_n, sleep, span, refsel, hsel, hwrite, hreadyout, hresp;
    logic [17:0] stage;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [9:0] code, pin_code, held;
    logic oe, valid, pd, span2v, extref;
    int errors = 0;
    int checks_done = 0;
    logic [17:0] pats [5] = '{18'h00000, 18'h20000, 18'h00001, 18'h3FFFF, 18'h04000};
    logic [9:0] exps [5] = '{10'h000, 10'h200, 10'h001, 10'h3FF, 10'h080};
    pacoc_top dut (.mclk_in(mclk_in), .rst_in(rst_in), .stage_codes_in(stage), .output_drive_enable_n_in(oe_n),
        .sleep_request_in(sleep), .span_select_in(span), .reference_source_select_in(refsel),
        .sample_code_out(code), .sample_code_oe_out(oe), .code_valid_out(valid), .power_down_out(pd),
        .span_2v_out(span2v), .ext_ref_out(extref), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(hresp));
    pacoc_capture_model cap (.mclk_in(mclk_in), .code_in(code), .oe_in(oe), .valid_in(valid),
        .pin_code_out(pin_code), .held_code_out(held));
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check
    task cyc(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : cyc
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge mclk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk_in); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task t_reset;
        cyc(8);
        check(oe, 1'b1, "drive at open pin");
        check({span2v, extref}, 2'h3, "open span and reference");
        ahb(1'b0, pacoc_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0, "control reset");
        ahb(1'b0, pacoc_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'h1E, "status after reset");
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
        ahb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0, "unmapped read");
        ahb(1'b0, pacoc_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h0, "unmapped write ignored");
        $display("reset test done");
    endtask : t_reset
    task t_code;
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk_in);
            stage <= pats[i];
            cyc(5);
            check(code, (i == 0) ? 10'h000 : exps[i-1], "code too early");
            cyc(1);
            check(code, exps[i], "corrected code");
            check(pin_code, exps[i], "code on pins");
            cyc(1);
            check(held, exps[i], "captured code");
        end
        ahb(1'b0, pacoc_pkg::CODE_OFS, 32'h0);
        check(rd, 32'h080, "code register");
        $display("code test done");
    endtask : t_code
    task t_oe;
        oe_n <= 1'b1;
        cyc(6);
        check(oe, 1'b0, "pins released by pin");
        check(pin_code, 10'h37F, "released pins float");
        @(posedge mclk_in);
        oe_n <= 1'b0;
        cyc(6);
        check(oe, 1'b1, "pins driven again");
        ahb(1'b1, pacoc_pkg::CTRL_OFS, 32'h2);
        cyc(2);
        check(oe, 1'b0, "pins released by control");
        ahb(1'b1, pacoc_pkg::CTRL_OFS, 32'h0);
        cyc(2);
        check(oe, 1'b1, "pins driven after control");
        $display("drive test done");
    endtask : t_oe
    task t_sleep;
        @(posedge mclk_in);
        sleep <= 1'b1;
        cyc(6);
        check({pd, valid}, 2'h2, "powered down");
        @(posedge mclk_in);
        stage <= 18'h2AAAB;
        cyc(8);
        check(code, 10'h080, "code held asleep");
        @(posedge mclk_in);
        sleep <= 1'b0;
        cyc(9);
        check(valid, 1'b0, "valid too early");
        cyc(1);
        check(valid, 1'b1, "valid on time");
        cyc(7);
        check({pd, valid, code}, {2'h1, 10'h3FF}, "running after wake");
        check(held, 10'h3FF, "capture after wake");
        ahb(1'b1, pacoc_pkg::CTRL_OFS, 32'h1);
        cyc(2);
        check(pd, 1'b1, "soft sleep");
        ahb(1'b0, pacoc_pkg::STATUS_OFS, 32'h0);
        check(rd, 32'hF, "status asleep");
        ahb(1'b0, pacoc_pkg::CTRL_OFS, 32'h0);
        check(rd, 32'h1, "control readback");
        ahb(1'b1, pacoc_pkg::CTRL_OFS, 32'h0);
        cyc(12);
        check({pd, valid}, 2'h1, "soft wake");
        $display("sleep test done");
    endtask : t_sleep
    task t_pins;
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk_in);
            span <= v[0];
            refsel <= v[0];
            cyc(6);
            check(span2v, v[0], "span output");
            check(extref, v[0], "reference output");
            ahb(1'b0, pacoc_pkg::STATUS_OFS, 32'h0);
            check(rd[3:2], {v[0], v[0]}, "status pins");
        end
        $display("pin test done");
    endtask : t_pins
    task results;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        rst_in = 1'b1;
        oe_n = 1'b0;
        sleep = 1'b0;
        span = 1'b1;
        refsel = 1'b1;
        stage = 18'h0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset;
        t_code;
        t_oe;
        t_sleep;
        t_pins;
        results;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #50us;
        errors++;
        results;
    end
endmodule : pacoc_top_test
`default_nettype wire
